//--- rtl/dncr_cmd_bank.sv
// Network command, speed reference and output value register bank
`include "dncr_defs.svh"
module dncr_cmd_bank #(
  parameter logic [15:0] SPEED_LIMIT = `DNCR_SPEED_LIMIT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Parameter access from serial or other sources
  input dncr_pkg::dncr_req_s req,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic wrRefused,
  // Drive configuration and state
  input wire logic [1:0] controlType,
  input wire logic [3:0] localSpeedSource,
  input wire logic [3:0] remoteSpeedSource,
  input wire logic [19:0] doFunction,
  input wire logic [11:0] aoFunction,
  input wire logic faultPresent,
  // Drive commands
  output dncr_pkg::dncr_drive_s drive,
  output logic speedRefValid,
  output logic [15:0] speedRefMag,
  // Outputs
  output logic [4:0] digitalOut,
  output logic [4:0] digitalOutNet,
  output logic [14:0] analogOut [3],
  output logic [2:0] analogOutNet,
  output logic [14:0] frequencyOut
);
  // Map register number to store index; 7 when unmapped
  function automatic logic [2:0] regIndex(input logic [15:0] num);
    unique case (num)
      `DNCR_REG_CMD: regIndex = 3'd0;
      `DNCR_REG_SPEED: regIndex = 3'd1;
      `DNCR_REG_DOUT: regIndex = 3'd2;
      `DNCR_REG_AOUT1: regIndex = 3'd3;
      `DNCR_REG_AOUT2: regIndex = 3'd4;
      `DNCR_REG_AOUT3: regIndex = 3'd5;
      default: regIndex = 3'd7;
    endcase
  endfunction

  // Write mask per index
  function automatic logic [15:0] regMask(input logic [2:0] idx);
    unique case (idx)
      3'd0: regMask = `DNCR_CMD_MASK;
      3'd2: regMask = `DNCR_DOUT_MASK;
      default: regMask = 16'hffff;
    endcase
  endfunction

  logic [2:0] wIdx;
  logic wrEn;
  logic [15:0] storeRd;
  logic [`DNCR_NUM_WORDS*16-1:0] words;
  logic rdValid_d, wrRefused_d, inMap;

  // Write acceptance: only serial source may write
  always_comb
  begin
    wIdx = regIndex(req.regNum);
    inMap = (wIdx != 3'd7);
    wrEn = req.write && inMap && req.fromSerial;
    wrRefused_d = req.write && inMap && !req.fromSerial;
    rdValid_d = req.read && inMap;
  end

  dncr_word_store #(
    .DEPTH(`DNCR_NUM_WORDS)
  ) uStore (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(wrEn),
    .wrIdx(wIdx),
    .wrData(req.wdata & regMask(wIdx)),
    .rdIdx(wIdx),
    .rdData(storeRd),
    .words(words)
  );

  logic [15:0] cmdW, spdW, doW;
  logic [15:0] aoW [3];
  assign cmdW = words[15:0];
  assign spdW = words[31:16];
  assign doW = words[47:32];
  genvar g;
  generate
    for (g = 0; g < `DNCR_NUM_AO; g++)
    begin : gAo
      assign aoW[g] = words[(g+3)*16 +: 16];
    end
  endgenerate

  dncr_pkg::dncr_drive_s drive_d;
  logic spdValid_d, serialSel, negRef;
  logic [15:0] mag_d;
  logic [4:0] dOut_d, dNet_d;
  logic [14:0] aOut_d [3];
  logic [2:0] aNet_d;
  logic rdPend_q;

  // Command decode
  always_comb
  begin
    drive_d.run = cmdW[`DNCR_BIT_RUN];
    drive_d.decelStop = !cmdW[`DNCR_BIT_RUN];
    drive_d.enable = cmdW[`DNCR_BIT_ENABLE];
    negRef = spdW[15];
    drive_d.forward = cmdW[`DNCR_BIT_DIR] ^ negRef;
    drive_d.inching_function = cmdW[`DNCR_BIT_JOG];
    drive_d.remote = cmdW[`DNCR_BIT_REMOTE];
    drive_d.ramp2 = cmdW[`DNCR_BIT_RAMP2];
    drive_d.quickStop = cmdW[`DNCR_BIT_QSTOP]
      && (controlType != `DNCR_CTL_SCALAR)
      && (controlType != `DNCR_CTL_VVEC);
    drive_d.faultReset = cmdW[`DNCR_BIT_FRESET] && faultPresent;
  end

  // Speed reference magnitude, limited
  always_comb
  begin
    serialSel = cmdW[`DNCR_BIT_REMOTE]
      ? (remoteSpeedSource == `DNCR_SRC_SERIAL)
      : (localSpeedSource == `DNCR_SRC_SERIAL);
    spdValid_d = serialSel;
    mag_d = negRef ? 16'(-spdW) : spdW;
    if (negRef && spdW == 16'h8000)
      mag_d = 16'h8000;
    if (mag_d > SPEED_LIMIT)
      mag_d = SPEED_LIMIT;
  end

  // Digital and analog output selection
  always_comb
  begin
    for (int i = 0; i < `DNCR_NUM_DO; i++)
    begin
      dNet_d[i] = doFunction[i*4 +: 4] == `DNCR_DO_FN_NET;
      dOut_d[i] = dNet_d[i] && doW[i];
    end
    for (int i = 0; i < `DNCR_NUM_AO; i++)
    begin
      aNet_d[i] = 1'b1;
      unique case (aoFunction[i*4 +: 4])
        `DNCR_AO_FN_V1: aOut_d[i] = aoW[0][14:0] & 15'h7fff;
        `DNCR_AO_FN_V2: aOut_d[i] = aoW[1][14:0];
        `DNCR_AO_FN_V3: aOut_d[i] = aoW[2][14:0];
        default:
        begin
          aOut_d[i] = 15'h0000;
          aNet_d[i] = 1'b0;
        end
      endcase
    end
  end

  // Register all outputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive <= '0;
      speedRefValid <= 1'b0;
      speedRefMag <= 16'h0000;
      digitalOut <= 5'h00;
      digitalOutNet <= 5'h00;
      analogOut <= '{default: 15'h0000};
      analogOutNet <= 3'h0;
      frequencyOut <= 15'h0000;
      rdValid <= 1'b0;
      wrRefused <= 1'b0;
      rdPend_q <= 1'b0;
    end
    else
    begin
      drive <= drive_d;
      speedRefValid <= spdValid_d;
      speedRefMag <= mag_d;
      digitalOut <= dOut_d;
      digitalOutNet <= dNet_d;
      analogOut <= aOut_d;
      analogOutNet <= aNet_d;
      frequencyOut <= aOut_d[2];
      rdValid <= rdValid_d;
      wrRefused <= wrRefused_d;
      rdPend_q <= rdValid_d;
    end
  end

  // Read data comes straight from the store register
  assign rdData = storeRd;

  // Checks
  property p_refuse_panel;
    @(posedge clk_sys) disable iff (!rst_n)
    (req.write && !req.fromSerial && regIndex(req.regNum) != 3'd7)
      |=> wrRefused && $stable(words);
  endproperty
  a_refuse_panel: assert property (p_refuse_panel)
    else $error("panel write changed bank");

  property p_cmd_reserved;
    @(posedge clk_sys) disable iff (!rst_n)
    cmdW[15:8] == 8'h00 && doW[15:5] == 11'h000;
  endproperty
  a_cmd_reserved: assert property (p_cmd_reserved)
    else $error("reserved bits stored");

  property p_serial_write;
    @(posedge clk_sys) disable iff (!rst_n)
    (req.write && req.fromSerial && req.regNum == `DNCR_REG_SPEED)
      |=> spdW == $past(req.wdata);
  endproperty
  a_serial_write: assert property (p_serial_write)
    else $error("serial write not stored");

  property p_run;
    @(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> drive.run == $past(cmdW[0]) && drive.decelStop != drive.run;
  endproperty
  a_run: assert property (p_run)
    else $error("run decode wrong");

  property p_dir;
    @(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> drive.forward == ($past(cmdW[2]) ^ $past(spdW[15]));
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction wrong");

  property p_qstop;
    @(posedge clk_sys) disable iff (!rst_n)
    (controlType == `DNCR_CTL_SCALAR || controlType == `DNCR_CTL_VVEC)
      |=> !drive.quickStop;
  endproperty
  a_qstop: assert property (p_qstop)
    else $error("quick stop under scalar");

  property p_freset;
    @(posedge clk_sys) disable iff (!rst_n)
    !faultPresent |=> !drive.faultReset;
  endproperty
  a_freset: assert property (p_freset)
    else $error("fault reset without fault");

  property p_limit;
    @(posedge clk_sys) disable iff (!rst_n)
    speedRefMag <= SPEED_LIMIT;
  endproperty
  a_limit: assert property (p_limit)
    else $error("speed not limited");

  property p_dout;
    @(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> digitalOut == ($past(doW[4:0]) & $past(dNet_d));
  endproperty
  a_dout: assert property (p_dout)
    else $error("digital output wrong");

  property p_fo;
    @(posedge clk_sys) disable iff (!rst_n)
    (aoFunction[11:8] == `DNCR_AO_FN_V1)
      |=> frequencyOut == $past(aoW[0][14:0]);
  endproperty
  a_fo: assert property (p_fo)
    else $error("frequency output mismatch");

  c_serial_cmd: cover property (@(posedge clk_sys) disable iff (!rst_n)
    req.write && req.fromSerial && req.regNum == `DNCR_REG_CMD);
  c_panel_refused: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wrRefused);
  c_reverse: cover property (@(posedge clk_sys) disable iff (!rst_n)
    drive.run && !drive.forward);
  c_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rdValid && rdPend_q);
endmodule

//--- rtl/dncr_word_store.sv
// Small register memory holding the network-written words
`include "dncr_defs.svh"
module dncr_word_store #(
  parameter int DEPTH = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Write port
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [15:0] wrData,
  // Read port
  input wire logic [2:0] rdIdx,
  output logic [15:0] rdData,
  // All words in parallel
  output logic [DEPTH*16-1:0] words
);
  logic [15:0] mem_q [DEPTH];
  logic [15:0] mem_d [DEPTH];
  logic [15:0] rdData_d;

  // Next contents and read word
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_d[i] = mem_q[i];
      if (wrEn && (int'(wrIdx) == i))
        mem_d[i] = wrData;
    end
    rdData_d = 16'h0000;
    for (int i = 0; i < DEPTH; i++)
      if (int'(rdIdx) == i)
        rdData_d = mem_q[i];
  end

  // Register contents
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= `DNCR_WORD_RESET;
      rdData <= `DNCR_WORD_RESET;
    end
    else
    begin
      mem_q <= mem_d;
      rdData <= rdData_d;
    end
  end

  // Flatten for parallel use
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : gFlat
      assign words[g*16 +: 16] = mem_q[g];
    end
  endgenerate
endmodule

//--- shared/dncr_defs.svh
// Register numbers, field positions and constants for the command bank
`ifndef DNCR_DEFS_SVH
`define DNCR_DEFS_SVH
`define DNCR_REG_CMD 16'h02aa
`define DNCR_REG_SPEED 16'h02ab
`define DNCR_REG_DOUT 16'h02b7
`define DNCR_REG_AOUT1 16'h02b8
`define DNCR_REG_AOUT2 16'h02b9
`define DNCR_REG_AOUT3 16'h02ba
`define DNCR_CMD_MASK 16'h00ff
`define DNCR_DOUT_MASK 16'h001f
`define DNCR_AOUT_MASK 16'h7fff
`define DNCR_CMD_RESET 16'h0000
`define DNCR_WORD_RESET 16'h0000
`define DNCR_BIT_RUN 0
`define DNCR_BIT_ENABLE 1
`define DNCR_BIT_DIR 2
`define DNCR_BIT_JOG 3
`define DNCR_BIT_REMOTE 4
`define DNCR_BIT_RAMP2 5
`define DNCR_BIT_QSTOP 6
`define DNCR_BIT_FRESET 7
`define DNCR_SPEED_LIMIT 16'h7fff
`define DNCR_SRC_SERIAL 4'h9
`define DNCR_DO_FN_NET 4'hc
`define DNCR_AO_FN_V1 4'h7
`define DNCR_AO_FN_V2 4'h8
`define DNCR_AO_FN_V3 4'h9
`define DNCR_CTL_SCALAR 2'h0
`define DNCR_CTL_VVEC 2'h3
`define DNCR_NUM_WORDS 6
`define DNCR_NUM_DO 5
`define DNCR_NUM_AO 3
`endif

//--- shared/dncr_pkg.sv
// Types shared by the command bank files
package dncr_pkg;
  typedef struct packed {
    logic write;
    logic read;
    logic fromSerial;
    logic [15:0] regNum;
    logic [15:0] wdata;
  } dncr_req_s;
  typedef struct packed {
    logic run;
    logic decelStop;
    logic enable;
    logic forward;
    logic inching_function;
    logic remote;
    logic ramp2;
    logic quickStop;
    logic faultReset;
  } dncr_drive_s;
endpackage

//--- verif/dncr_net_master.sv
// Network master model issuing single parameter reads and writes
module dncr_net_master (
  // Clock
  input wire logic clk_sys,
  // Parameter access
  output dncr_pkg::dncr_req_s req,
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  input wire logic wrRefused
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // Held over the taking edge, then released with inverted junk
  task automatic access(input logic wr, input logic ser,
    input logic [15:0] num, input logic [15:0] dat,
    output logic [15:0] rd, output logic vld, output logic refu);
    @(posedge clk_sys);
    req <= '{wr, ~wr, ser, num, dat};
    @(posedge clk_sys);
    req <= '{1'b0, 1'b0, ~ser, ~num, ~dat};
    #1;
    rd = rdData;
    vld = rdValid;
    refu = wrRefused;
  endtask
endmodule

//--- verif/drive_network_command_regs_tb_top.sv
// Self-checking bench for the network command register bank
`include "dncr_defs.svh"
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("MISMATCH %s exp %h got %h", nm, exp, got); \
    end \
  end
module drive_network_command_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  dncr_pkg::dncr_req_s req;
  logic [15:0] rdData;
  logic rdValid, wrRefused, speedRefValid;
  logic [1:0] controlType = 2'h1;
  logic [3:0] localSpeedSource = 4'h9;
  logic [3:0] remoteSpeedSource = 4'h0;
  logic [19:0] doFunction = 20'h00000;
  logic [11:0] aoFunction = 12'h000;
  logic faultPresent = 1'b1;
  dncr_pkg::dncr_drive_s drive;
  logic [15:0] speedRefMag;
  logic [4:0] digitalOut, digitalOutNet;
  logic [14:0] analogOut [3];
  logic [2:0] analogOutNet;
  logic [14:0] frequencyOut;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [15:0] rd;
  logic vld, refu;
  dncr_cmd_bank i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
    .rdData(rdData), .rdValid(rdValid), .wrRefused(wrRefused),
    .controlType(controlType), .localSpeedSource(localSpeedSource),
    .remoteSpeedSource(remoteSpeedSource), .doFunction(doFunction),
    .aoFunction(aoFunction), .faultPresent(faultPresent), .drive(drive),
    .speedRefValid(speedRefValid), .speedRefMag(speedRefMag),
    .digitalOut(digitalOut), .digitalOutNet(digitalOutNet),
    .analogOut(analogOut), .analogOutNet(analogOutNet),
    .frequencyOut(frequencyOut));
  dncr_net_master i_master (.clk_sys(clk_sys), .req(req), .rdData(rdData),
    .rdValid(rdValid), .wrRefused(wrRefused));
  // Clock generation
  initial forever #4 clk_sys = ~clk_sys;
  // Verdict and end of run
  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Serial write, never refused
  task automatic wr(input logic [15:0] num, input logic [15:0] dat);
    i_master.access(1'b1, 1'b1, num, dat, rd, vld, refu);
    `CHK("wrRefused", 1'b0, refu)
  endtask
  // Read with expected word
  task automatic rdchk(input logic [15:0] num, input logic [15:0] exp);
    i_master.access(1'b0, 1'b1, num, 16'h0000, rd, vld, refu);
    `CHK("rdValid", 1'b1, vld)
    `CHK("rdData", exp, rd)
  endtask
  // Command write, then drive check one cycle on
  task automatic cmd(input logic [15:0] c, input logic neg);
    dncr_pkg::dncr_drive_s e;
    dncr_pkg::dncr_drive_s d;
    wr(`DNCR_REG_CMD, c);
    @(posedge clk_sys);
    #1;
    d = drive;
    e = '{c[0], ~c[0], c[1], c[2] ^ neg, c[3], c[4], c[5],
      c[6] && controlType != 2'h0 && controlType != 2'h3,
      c[7] && faultPresent};
    `CHK("drive", e, d)
  endtask
  // Reset values
  task automatic t_reset();
    rdchk(`DNCR_REG_CMD, 16'h0000);
    rdchk(`DNCR_REG_DOUT, 16'h0000);
    rdchk(`DNCR_REG_AOUT1, 16'h0000);
    `CHK("driveRst", 19'h20000, ({drive, digitalOut, digitalOutNet}))
  endtask
  // Each command bit, gating of quick stop and fault reset
  task automatic t_cmd();
    wr(`DNCR_REG_SPEED, 16'h0000);
    for (int i = 0; i < 8; i++)
      cmd(16'h0001 << i, 1'b0);
    cmd(16'hffff, 1'b0);
    rdchk(`DNCR_REG_CMD, 16'h00ff);
    @(posedge clk_sys) controlType <= 2'h0;
    cmd(16'h0040, 1'b0);
    @(posedge clk_sys) controlType <= 2'h3;
    cmd(16'h0040, 1'b0);
    @(posedge clk_sys) faultPresent <= 1'b0;
    cmd(16'h0080, 1'b0);
  endtask
  // Speed scale, sign with direction, saturation, source selection
  task automatic t_speed();
    logic [15:0] v [6] = '{16'h0000, 16'h2000, 16'he000, 16'h7fff,
      16'h8000, 16'h0001};
    logic [15:0] m [6] = '{16'h0000, 16'h2000, 16'h2000, 16'h7fff,
      16'h7fff, 16'h0001};
    for (int i = 0; i < 12; i++)
    begin
      wr(`DNCR_REG_SPEED, v[i/2]);
      cmd({13'h0000, i[0], 2'h3}, v[i/2][15]);
      `CHK("speedRefMag", m[i/2], speedRefMag)
      `CHK("speedRefValid", 1'b1, speedRefValid)
      rdchk(`DNCR_REG_SPEED, v[i/2]);
    end
    cmd(16'h0010, 1'b0);
    `CHK("srcRemote", 1'b0, speedRefValid)
    @(posedge clk_sys) remoteSpeedSource <= 4'h9;
    localSpeedSource <= 4'h2;
    cmd(16'h0010, 1'b0);
    `CHK("srcRemote", 1'b1, speedRefValid)
    cmd(16'h0000, 1'b0);
    `CHK("srcLocal", 1'b0, speedRefValid)
  endtask
  // Non-serial writes refused, unmapped numbers ignored
  task automatic t_refuse();
    logic [15:0] r [6] = '{`DNCR_REG_CMD, `DNCR_REG_SPEED, `DNCR_REG_DOUT,
      `DNCR_REG_AOUT1, `DNCR_REG_AOUT2, `DNCR_REG_AOUT3};
    for (int i = 0; i < 6; i++)
    begin
      wr(r[i], 16'h0001);
      i_master.access(1'b1, 1'b0, r[i], 16'h0006, rd, vld, refu);
      `CHK("panelWrite", 1'b1, refu)
      rdchk(r[i], 16'h0001);
    end
    i_master.access(1'b0, 1'b1, 16'h02a9, 16'h0000, rd, vld, refu);
    `CHK("unmapped", 1'b0, vld)
    i_master.access(1'b1, 1'b0, 16'h02ac, 16'h0006, rd, vld, refu);
    `CHK("unmappedWr", 1'b0, refu)
  endtask
  // Digital and analog outputs under their function selections
  task automatic t_outputs();
    @(posedge clk_sys) doFunction <= 20'h0c0cc;
    aoFunction <= 12'h798;
    wr(`DNCR_REG_DOUT, 16'hffea);
    wr(`DNCR_REG_AOUT1, 16'h1234);
    wr(`DNCR_REG_AOUT2, 16'h7fff);
    wr(`DNCR_REG_AOUT3, 16'h4321);
    rdchk(`DNCR_REG_DOUT, 16'h000a);
    `CHK("doNet", 5'h0b, digitalOutNet)
    `CHK("doOut", 5'h0a, digitalOut)
    `CHK("ao", ({15'h7fff, 15'h4321, 15'h1234}), ({analogOut[0], analogOut[1],
      analogOut[2]}))
    `CHK("aoNet", 3'h7, analogOutNet)
    `CHK("fo", 15'h1234, frequencyOut)
    @(posedge clk_sys) doFunction <= 20'hccccc;
    aoFunction <= 12'h708;
    wr(`DNCR_REG_DOUT, 16'h0015);
    @(posedge clk_sys);
    #1;
    `CHK("doAll", 5'h15, digitalOut)
    `CHK("aoNet2", 3'h5, analogOutNet)
    `CHK("aoOff", 15'h0000, analogOut[1])
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_cmd();
    t_speed();
    t_refuse();
    t_outputs();
    finish_test();
  end
endmodule
